// *** cmdc_ctrl_model.sv ***
/* Motion controller model: converter level and duty-cycle command.
   Assumes the bench sets level and on-time on the drive clock. */
`timescale 1ns/100ps

module cmdc_ctrl_model #(
   parameter PERIOD = 64
) (
   // Clock
   input  wire        aclk,
   // Settings
   input  wire [15:0] level,
   input  wire [7:0]  on_time,
   // Command pins
   output reg  [15:0] adc_sample = 16'h0000,
   output reg         pwm_out = 1'b0
);
   reg [7:0] phase = 8'h00;

   // Carrier of 3.125 MHz keeps any break setting far below it
   always @(posedge aclk) begin
      adc_sample <= level;
      phase <= (phase == PERIOD - 1) ? 8'h00 : phase + 8'h01;
      pwm_out <= (phase < on_time);
   end
endmodule // cmdc_ctrl_model

// *** cmdc_defs.vh ***
/*
 * Constants of the command conditioning block: register offsets, field
 * positions, reset values, filter limits and timing counts.
 * Assumes inclusion by cmdc_top.v, cmdc_pole.v and the bench.
 */
`ifndef CMDC_DEFS_VH
`define CMDC_DEFS_VH

// Register byte offsets
`define CMDC_ADDR_CTRL      8'h00
`define CMDC_ADDR_GAIN      8'h04
`define CMDC_ADDR_OFFSET    8'h08
`define CMDC_ADDR_BREAK     8'h0C
`define CMDC_ADDR_SWCMD     8'h10
`define CMDC_ADDR_STATUS    8'h14
`define CMDC_ADDR_NVOFFSET  8'h18
`define CMDC_ADDR_LOOPCMD   8'h1C

// Control register fields
`define CMDC_CTRL_SRC_LSB   0
`define CMDC_CTRL_MODE_LSB  2
`define CMDC_CTRL_NULL_BIT  4
`define CMDC_CTRL_RST       32'h0000_0010

// Source selector codes
`define CMDC_SRC_ANALOG     2'h0
`define CMDC_SRC_DUTY       2'h1
`define CMDC_SRC_SW_ANALOG  2'h2
`define CMDC_SRC_SW_DUTY    2'h3

// Loop operating mode codes
`define CMDC_MODE_CURRENT   2'h0
`define CMDC_MODE_VELOCITY  2'h1
`define CMDC_MODE_POSITION  2'h2

// Auto-null control values
`define CMDC_NULL_ENABLE    1'b0

// Reset values of data registers and gain limit
`define CMDC_GAIN_RST       16'h0100
`define CMDC_GAIN_MAX       16'h7FFF
`define CMDC_OFFSET_RST     16'h0000
`define CMDC_SWCMD_RST      16'h0000

// Break frequency in millihertz
`define CMDC_BREAK_MIN      32'd1518
`define CMDC_BREAK_MAX      32'd93254000
`define CMDC_GAP_LO         32'd2915000
`define CMDC_GAP_HI         32'd24873000
`define CMDC_BREAK_RST      32'd93254000

// Timing
`define CMDC_CLK_HZ         200000000
`define CMDC_FILT_DIV       1000
`define CMDC_FILT_HZ        (`CMDC_CLK_HZ / `CMDC_FILT_DIV)
// Alpha (Q16) = mHz * MUL >> 16, MUL = 2*pi*2^32 / (sample rate * 1000), rounded
// Split into two scalings so 32-bit integer arithmetic does not overflow
`define CMDC_ALPHA_MUL      ((411775 * 4096 / `CMDC_FILT_HZ * 16 + 500) / 1000)
`define CMDC_NULL_HOLD_S    1
`define CMDC_NULL_HOLD_CYC  (`CMDC_NULL_HOLD_S * `CMDC_CLK_HZ)
`define CMDC_DUTY_WIN_LOG2  12

// AXI responses
`define CMDC_RESP_OKAY      2'b00
`define CMDC_RESP_SLVERR    2'b10

`endif

// *** cmdc_pole.v ***
/*
 * One single-pole low-pass stage, y += alpha * (x - y), Q16 alpha.
 * Assumes a sample enable pulse from a divider on the same clock.
 */
`timescale 1ns/100ps
`include "cmdc_defs.vh"

module cmdc_pole #(
   parameter W = 16
) (
   // Clock and reset
   input  wire                aclk,
   input  wire                aresetn,
   // Sample control
   input  wire                sample_en,
   input  wire                bypass,
   input  wire [16:0]         alpha,
   // Data
   input  wire signed [W-1:0] din,
   output wire signed [W-1:0] dout
);
   reg  signed [W+15:0] acc;
   wire signed [W+16:0] diff = {din[W-1], din, 16'h0000} - {acc[W+15], acc};
   wire signed [W+34:0] prod = diff * $signed({1'b0, alpha});
   wire signed [W+15:0] step = prod[W+31:16];

   always @(posedge aclk) begin
      if (!aresetn) begin
         acc <= {(W+16){1'b0}};
      end else if (sample_en) begin
         if (bypass) begin
            acc <= {din, 16'h0000};
         end else begin
            acc <= acc + step;
         end
      end
   end

   assign dout = acc[W+15:16];
endmodule // cmdc_pole

// *** cmdc_top.v ***
/*
 * Servo command conditioning: source select, offset, signed gain,
 * two cascaded low-pass stages and auto-null, behind an AXI4-Lite slave.
 * Assumes the converter sample arrives on aclk; the duty-cycle and
 * digital inputs are asynchronous pins.
 */
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "cmdc_defs.vh"

module cmdc_top #(
   parameter [31:0] NULL_HOLD_CYC = `CMDC_NULL_HOLD_CYC,
   parameter        DUTY_WIN_LOG2 = `CMDC_DUTY_WIN_LOG2
) (
   // Clock and reset
   input  wire              aclk,
   input  wire              aresetn,
   // AXI4-Lite write address
   input  wire [7:0]        s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   // AXI4-Lite read address
   input  wire [7:0]        s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   // Command inputs
   input  wire signed [15:0] adc_sample,
   input  wire              duty_cycle_command_input,
   input  wire              digital_input_four,
   // Conditioned command and stored offset
   output wire signed [15:0] scaled_loop_command,
   output reg               nv_offset_write,
   output reg  [15:0]       nv_offset_data
);
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   function signed [15:0] sat16;
      input signed [32:0] v;
      begin
         if (v > 33'sd32767) begin
            sat16 = 16'sh7FFF;
         end else if (v < -33'sd32768) begin
            sat16 = 16'sh8000;
         end else begin
            sat16 = v[15:0];
         end
      end
   endfunction

   function [15:0] abs16;
      input signed [15:0] v;
      begin
         abs16 = v[15] ? (~v + 16'h0001) : v;
      end
   endfunction

   // Registers
   reg  [31:0]        ctrl;
   reg  signed [15:0] gain;
   reg  signed [15:0] offset;
   reg  [31:0]        brk;
   reg  signed [15:0] sw_cmd;
   reg  [16:0]        alpha;
   reg                bypass;

   wire [1:0] src  = ctrl[`CMDC_CTRL_SRC_LSB +: 2];
   wire [1:0] loop_operating_mode = ctrl[`CMDC_CTRL_MODE_LSB +: 2];
   wire       auto_null_control = ctrl[`CMDC_CTRL_NULL_BIT];

   // Pin synchronisers
   reg [1:0] duty_sync;
   reg [1:0] din4_sync;
   always @(posedge aclk) begin
      if (!aresetn) begin
         duty_sync <= 2'b00;
         din4_sync <= 2'b00;
      end else begin
         duty_sync <= {duty_sync[0], duty_cycle_command_input};
         din4_sync <= {din4_sync[0], digital_input_four};
      end
   end
   wire duty_s = duty_sync[1];
   wire din4_s = din4_sync[1];

   // Duty measurement over a fixed window, 50 % reads as zero
   reg  [DUTY_WIN_LOG2-1:0] win_cnt;
   reg  [DUTY_WIN_LOG2:0]   high_cnt;
   reg  signed [15:0]       duty_val;
   wire signed [32:0] duty_ctr = $signed({{(32-DUTY_WIN_LOG2){1'b0}}, high_cnt})
                                 - $signed(33'd1 << (DUTY_WIN_LOG2 - 1));
   always @(posedge aclk) begin
      if (!aresetn) begin
         win_cnt  <= {DUTY_WIN_LOG2{1'b0}};
         high_cnt <= {(DUTY_WIN_LOG2+1){1'b0}};
         duty_val <= 16'sh0000;
      end else begin
         win_cnt <= win_cnt + 1'b1;
         if (&win_cnt) begin
            duty_val <= sat16(duty_ctr <<< (16 - DUTY_WIN_LOG2));
            high_cnt <= {{DUTY_WIN_LOG2{1'b0}}, duty_s};
         end else begin
            high_cnt <= high_cnt + {{DUTY_WIN_LOG2{1'b0}}, duty_s};
         end
      end
   end

   // Source selection; software value dropped in position mode
   reg signed [15:0] user_in;
   always @* begin
      case (src)
         `CMDC_SRC_ANALOG: user_in = adc_sample;
         `CMDC_SRC_DUTY:   user_in = duty_val;
         default: begin
            if (loop_operating_mode == `CMDC_MODE_POSITION) begin
               user_in = 16'sh0000;
            end else begin
               user_in = sw_cmd;
            end
         end
      endcase
   end

   // Gain limit falls linearly with offset magnitude
   wire [15:0] off_abs = abs16(offset);
   wire [31:0] lim_red = {16'h0000, `CMDC_GAIN_MAX} * {16'h0000, off_abs};
   wire [15:0] g_lim   = `CMDC_GAIN_MAX - lim_red[30:15];
   wire [15:0] g_abs   = abs16(gain);
   wire signed [15:0] g_lim_s = g_lim;
   wire signed [15:0] g_eff = (g_abs <= g_lim) ? gain :
                              (gain[15] ? -g_lim_s : g_lim_s);

   // Offset subtract then signed Q8.8 gain
   wire signed [16:0] diff  = {user_in[15], user_in} - {offset[15], offset};
   wire signed [32:0] prod  = diff * g_eff;
   wire signed [15:0] cmd_raw = sat16(prod >>> 8);

   // Filter sample rate divider
   reg [15:0] div_cnt;
   wire       filt_en = (div_cnt == `CMDC_FILT_DIV - 1);
   always @(posedge aclk) begin
      if (!aresetn || filt_en) begin
         div_cnt <= 16'h0000;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   wire signed [15:0] stage1;
   cmdc_pole #(.W(16)) u_pole_a (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .sample_en (filt_en),
      .bypass    (bypass),
      .alpha     (alpha),
      .din       (cmd_raw),
      .dout      (stage1)
   );
   cmdc_pole #(.W(16)) u_pole_b (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .sample_en (filt_en),
      .bypass    (bypass),
      .alpha     (alpha),
      .din       (stage1),
      .dout      (scaled_loop_command)
   );

   // Auto-null hold timer, one update per assertion
   reg  [31:0] hold_cnt;
   reg         null_done;
   wire        null_fire = (auto_null_control == `CMDC_NULL_ENABLE) && din4_s &&
                           !null_done && (hold_cnt == NULL_HOLD_CYC - 1);
   always @(posedge aclk) begin
      if (!aresetn) begin
         hold_cnt  <= 32'h0000_0000;
         null_done <= 1'b0;
      end else if (!din4_s || auto_null_control != `CMDC_NULL_ENABLE) begin
         hold_cnt  <= 32'h0000_0000;
         null_done <= 1'b0;
      end else if (null_fire) begin
         null_done <= 1'b1;
      end else if (!null_done) begin
         hold_cnt <= hold_cnt + 32'h0000_0001;
      end
   end

   // AXI write channel: address and data taken in either order
   reg        aw_held;
   reg        w_held;
   reg [7:0]  aw_addr;
   reg [31:0] w_data;
   reg [3:0]  w_strb;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   wire [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wd = w_held ? w_data : s_axi_wdata;
   wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
   wire        wr_go = (aw_held || aw_take) && (w_held || w_take);

   wire [31:0] brk_new = merge(brk, wd, ws);
   wire [31:0] gain_new = merge({16'h0000, gain}, wd, ws);
   wire [31:0] off_new  = merge({16'h0000, offset}, wd, ws);
   wire [31:0] sw_new   = merge({16'h0000, sw_cmd}, wd, ws);
   wire        brk_ok  = (brk_new >= `CMDC_BREAK_MIN) && (brk_new <= `CMDC_BREAK_MAX) &&
                         !((brk_new >= `CMDC_GAP_LO) && (brk_new <= `CMDC_GAP_HI));
   wire [47:0] alpha_w = {16'h0000, brk_new} * `CMDC_ALPHA_MUL;
   wire        wr_map  = (wa == `CMDC_ADDR_CTRL) || (wa == `CMDC_ADDR_GAIN) ||
                         (wa == `CMDC_ADDR_OFFSET) || (wa == `CMDC_ADDR_SWCMD) ||
                         ((wa == `CMDC_ADDR_BREAK) && brk_ok);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CMDC_RESP_OKAY;
      end else begin
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `CMDC_RESP_OKAY : `CMDC_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held <= 1'b1;
               aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
               w_held <= 1'b1;
               w_data <= s_axi_wdata;
               w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
      end
   end

   // Register file; auto-null wins over a software offset write
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl            <= `CMDC_CTRL_RST;
         gain            <= `CMDC_GAIN_RST;
         offset          <= `CMDC_OFFSET_RST;
         brk             <= `CMDC_BREAK_RST;
         sw_cmd          <= `CMDC_SWCMD_RST;
         alpha           <= 17'h10000;
         bypass          <= 1'b1;
         nv_offset_write <= 1'b0;
         nv_offset_data  <= `CMDC_OFFSET_RST;
      end else begin
         nv_offset_write <= 1'b0;
         if (wr_go && wr_map) begin
            case (wa)
               `CMDC_ADDR_CTRL:   ctrl   <= merge(ctrl, wd, ws) & 32'h0000_001F;
               `CMDC_ADDR_GAIN:   gain   <= gain_new[15:0];
               `CMDC_ADDR_OFFSET: offset <= off_new[15:0];
               `CMDC_ADDR_SWCMD:  sw_cmd <= sw_new[15:0];
               `CMDC_ADDR_BREAK: begin
                  brk    <= brk_new;
                  bypass <= (brk_new > `CMDC_GAP_HI);
                  alpha  <= (alpha_w[47:16] >= 32'h0001_0000) ? 17'h10000 :
                            ((alpha_w[47:16] == 32'h0) ? 17'h00001 : alpha_w[32:16]);
               end
               default: ;
            endcase
         end
         if (null_fire) begin
            offset          <= adc_sample;
            nv_offset_write <= 1'b1;
            nv_offset_data  <= adc_sample;
         end
      end
   end

   // Status: unit set in bits 1:0, null hold active, bypass, limit
   wire [1:0] unit_set = {src[0], loop_operating_mode == `CMDC_MODE_VELOCITY};
   wire [31:0] status = {g_lim, 12'h000, bypass, din4_s && !null_done &&
                         (auto_null_control == `CMDC_NULL_ENABLE), unit_set};

   // AXI read channel
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `CMDC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `CMDC_RESP_OKAY;
         case (s_axi_araddr)
            `CMDC_ADDR_CTRL:     s_axi_rdata <= ctrl;
            `CMDC_ADDR_GAIN:     s_axi_rdata <= {16'h0000, gain};
            `CMDC_ADDR_OFFSET:   s_axi_rdata <= {16'h0000, offset};
            `CMDC_ADDR_BREAK:    s_axi_rdata <= brk;
            `CMDC_ADDR_SWCMD:    s_axi_rdata <= {16'h0000, sw_cmd};
            `CMDC_ADDR_STATUS:   s_axi_rdata <= status;
            `CMDC_ADDR_NVOFFSET: s_axi_rdata <= {16'h0000, nv_offset_data};
            `CMDC_ADDR_LOOPCMD:  s_axi_rdata <= {16'h0000, scaled_loop_command};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `CMDC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // cmdc_top

// *** cmdc_top_properties.sv ***
/* Port checks for cmdc_top: bus answers and auto-null.
   Assumes binding to every cmdc_top instance. */
`timescale 1ns/100ps

module cmdc_props #(
   parameter [31:0] NULL_HOLD_CYC = 32'h0000_0014
) (
   // Clock and reset
   input wire               aclk,
   input wire               aresetn,
   // Register bus
   input wire               s_axi_awvalid,
   input wire               s_axi_awready,
   input wire               s_axi_wvalid,
   input wire               s_axi_wready,
   input wire [1:0]         s_axi_bresp,
   input wire               s_axi_bvalid,
   input wire               s_axi_bready,
   input wire               s_axi_arvalid,
   input wire               s_axi_arready,
   input wire [31:0]        s_axi_rdata,
   input wire               s_axi_rvalid,
   input wire               s_axi_rready,
   // Auto-null
   input wire signed [15:0] adc_sample,
   input wire               digital_input_four,
   input wire               nv_offset_write,
   input wire [15:0]        nv_offset_data
);
   reg [31:0] hi_cnt;

   // Cycles the raw input four has stayed high
   always @(posedge aclk) begin
      if (!aresetn || !digital_input_four)
         hi_cnt <= 32'h0000_0000;
      else if (hi_cnt != 32'hFFFF_FFFF)
         hi_cnt <= hi_cnt + 32'h0000_0001;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_wr_answer: assert property (s_wr_both |=> s_axi_bvalid)
      else $error("write answer late");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read answer late");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_nv_single: assert property (nv_offset_write |=> !nv_offset_write)
      else $error("store pulse too long");
   a_nv_only: assert property (!$stable(nv_offset_data) |-> nv_offset_write)
      else $error("stored offset changed without pulse");
   a_nv_value: assert property (nv_offset_write |-> nv_offset_data == $past(adc_sample))
      else $error("stored offset not the sample");
   a_null_hold: assert property (nv_offset_write |-> hi_cnt >= NULL_HOLD_CYC)
      else $error("null before hold time");
endmodule // cmdc_props

bind cmdc_top cmdc_props #(.NULL_HOLD_CYC(NULL_HOLD_CYC)) cmdc_props_i (
   .aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .adc_sample(adc_sample), .digital_input_four(digital_input_four),
   .nv_offset_write(nv_offset_write), .nv_offset_data(nv_offset_data)
);

// *** cmdc_top_tb.sv ***
/* Self-checking bench for cmdc_top.
   Assumes the controller model on the pins and the bound checker. */
`timescale 1ns/100ps
`include "cmdc_defs.vh"

module cmdc_top_tb;
   localparam [1:0] OK = `CMDC_RESP_OKAY;
   localparam [1:0] ER = `CMDC_RESP_SLVERR;
   reg         aclk = 1'b0;
   reg         aresetn, awvalid, wvalid, bready, arvalid, rready, din4;
   reg  [7:0]  addr;
   reg  [31:0] wdata, last_brk, q;
   reg  [15:0] lvl;
   reg  [1:0]  r;
   reg  [3:0]  strb;
   wire        awready, wready, bvalid, arready, rvalid, pwm, nv_wr;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] adc, cmd, nv_data;
   integer     n_fail, compares, pulses;

   cmdc_top #(.NULL_HOLD_CYC(32'h0000_0014)) cmdc_top_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(addr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(addr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .adc_sample(adc), .duty_cycle_command_input(pwm), .digital_input_four(din4),
      .scaled_loop_command(cmd), .nv_offset_write(nv_wr), .nv_offset_data(nv_data)
   );
   cmdc_ctrl_model cmdc_ctrl_model_i (
      .aclk(aclk), .level(lvl), .on_time(8'h30), .adc_sample(adc), .pwm_out(pwm)
   );

   always #2.5 aclk = ~aclk;

   always @(negedge aclk)
      if (nv_wr === 1'b1)
         pulses = pulses + 1;

   task conclude;
      begin
         $display("compares %0d n_fail %0d", compares, n_fail);
         if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   task chk(input [31:0] g, input [31:0] e);
      begin
         compares = compares + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
         end
      end
   endtask

   // One transfer; ready for the answer is raised once it is offered
   task bus(input wr, input [7:0] a, input [31:0] d);
      reg [2:0] p;
      reg       ta, tw, tr, vr;
      integer   k;
      begin
         @(posedge aclk);
         addr <= a;
         wdata <= d;
         awvalid <= wr;
         wvalid <= wr;
         arvalid <= !wr;
         p = wr ? 3'b111 : 3'b101;
         for (k = 0; k < 200 && p != 3'b000; k = k + 1) begin
            @(negedge aclk);
            ta = wr ? awvalid && awready : arvalid && arready;
            tw = wvalid && wready;
            vr = wr ? bvalid : rvalid;
            tr = vr && (wr ? bready : rready);
            q = rdata;
            r = wr ? bresp : rresp;
            @(posedge aclk);
            if (ta) begin
               p[0] = 1'b0;
               awvalid <= 1'b0;
               arvalid <= 1'b0;
            end
            if (tw) begin
               p[1] = 1'b0;
               wvalid <= 1'b0;
            end
            if (tr)
               p[2] = 1'b0;
            bready <= vr && !tr && wr;
            rready <= vr && !tr && !wr;
         end
         if (p != 3'b000) begin
            n_fail = n_fail + 1;
            conclude;
         end
      end
   endtask

   task rchk(input [7:0] a, input [31:0] e, input [1:0] er);
      begin
         bus(1'b0, a, 32'h0000_0000);
         chk(q, e);
         chk({30'h0, r}, {30'h0, er});
      end
   endtask

   task wchk(input [7:0] a, input [31:0] d, input [1:0] er);
      begin
         bus(1'b1, a, d);
         chk({30'h0, r}, {30'h0, er});
      end
   endtask

   // Three filter ticks in bypass, then port and register agree
   task settle(input [15:0] e);
      begin
         repeat (3000) @(posedge aclk);
         chk({16'h0000, cmd}, {16'h0000, e});
         rchk(8'h1C, {16'h0000, e}, OK);
      end
   endtask

   task brk(input [31:0] v, input ok);
      begin
         wchk(8'h0C, v, ok ? OK : ER);
         if (ok)
            last_brk = v;
         rchk(8'h0C, last_brk, OK);
         bus(1'b0, 8'h14, 32'h0000_0000);
         chk({31'h0, q[3]}, {31'h0, last_brk > `CMDC_GAP_HI});
      end
   endtask

   task src(input [4:0] c, input [15:0] e);
      begin
         wchk(8'h00, {27'h0, c}, OK);
         repeat (5000) @(posedge aclk);
         settle(e);
         bus(1'b0, 8'h14, 32'h0000_0000);
         chk({30'h0, q[1:0]}, {30'h0, c[0], c[3:2] == 2'h1});
      end
   endtask

   task hold(input integer n);
      begin
         @(posedge aclk);
         din4 <= 1'b1;
         repeat (n) @(posedge aclk);
         din4 <= 1'b0;
         repeat (5) @(posedge aclk);
      end
   endtask

   task t_reset;
      begin
         rchk(8'h00, 32'h0000_0010, OK);
         rchk(8'h04, 32'h0000_0100, OK);
         rchk(8'h08, 32'h0000_0000, OK);
         rchk(8'h0C, `CMDC_BREAK_MAX, OK);
         rchk(8'h10, 32'h0000_0000, OK);
         rchk(8'h20, 32'h0000_0000, ER);
         wchk(8'h1C, 32'h0000_0001, ER);
         // Low byte lane only: upper byte of the scale factor must stay
         strb <= 4'h1;
         wchk(8'h04, 32'h0000_0033, OK);
         strb <= 4'hF;
         rchk(8'h04, 32'h0000_0133, OK);
         wchk(8'h04, 32'h0000_0100, OK);
      end
   endtask

   task t_break;
      begin
         brk(`CMDC_BREAK_MIN - 32'h1, 1'b0);
         brk(`CMDC_BREAK_MIN, 1'b1);
         brk(`CMDC_GAP_LO - 32'h1, 1'b1);
         brk(`CMDC_GAP_LO, 1'b0);
         brk(`CMDC_GAP_HI, 1'b0);
         brk(`CMDC_GAP_HI + 32'h1, 1'b1);
         brk(`CMDC_BREAK_MAX + 32'h1, 1'b0);
         brk(`CMDC_BREAK_MAX, 1'b1);
      end
   endtask

   task t_path;
      begin
         lvl <= 16'h1100;
         wchk(8'h08, 32'h0000_0100, OK);
         wchk(8'h04, 32'h0000_0200, OK);
         settle(16'h2000);
         wchk(8'h04, 32'h0000_FE00, OK);
         settle(16'hE000);
         lvl <= 16'h4100;
         wchk(8'h08, 32'h0000_4000, OK);
         wchk(8'h04, 32'h0000_7FFF, OK);
         settle(16'h4000);
         bus(1'b0, 8'h14, 32'h0000_0000);
         chk({16'h0000, q[31:16]}, 32'h0000_4000);
         wchk(8'h08, 32'h0000_0000, OK);
         wchk(8'h04, 32'h0000_0100, OK);
      end
   endtask

   task t_source;
      begin
         lvl <= 16'h1234;
         wchk(8'h10, 32'h0000_0300, OK);
         src(5'h10, 16'h1234);
         src(5'h15, 16'h4000);
         src(5'h12, 16'h0300);
         src(5'h17, 16'h0300);
         src(5'h1A, 16'h0000);
         wchk(8'h00, 32'h0000_0010, OK);
      end
   endtask

   task t_null;
      begin
         lvl <= 16'h0ABC;
         pulses = 0;
         hold(40);
         chk(pulses, 0);
         wchk(8'h00, 32'h0000_0000, OK);
         hold(15);
         chk(pulses, 0);
         hold(40);
         chk(pulses, 1);
         chk({16'h0000, nv_data}, 32'h0000_0ABC);
         rchk(8'h18, 32'h0000_0ABC, OK);
         rchk(8'h08, 32'h0000_0ABC, OK);
      end
   endtask

   initial begin
      n_fail = 0;
      compares = 0;
      pulses = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, din4} = 6'h00;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      strb = 4'hF;
      lvl = 16'h0000;
      last_brk = `CMDC_BREAK_MAX;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_break;
      t_path;
      t_source;
      t_null;
      conclude;
   end
endmodule // cmdc_top_tb
